// File: hw/fvr_accel.sv
// Vector reduce datapath, its word buffer and memory masters
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Word buffer between compute and write master
module fvr_fifo #(
    parameter int WIDTH = 512,                           // Word width
    parameter int DEPTH = 32                             // Word count
) (
    input  wire logic                     clock,         // Clock
    input  wire logic                     resetn,        // Async reset
    input  wire logic                     in_valid,      // Push request
    output logic                          in_ready,      // Room left
    input  wire logic [WIDTH-1:0]         in_data,       // Pushed word
    output logic                          out_valid,     // Word present
    input  wire logic                     out_ready,     // Pop request
    output logic [WIDTH-1:0]              out_data,      // Head word
    output logic [$clog2(DEPTH):0]        count          // Occupancy
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];                       // Storage
    logic [AW-1:0]    wp_r;                              // Write pointer
    logic [AW-1:0]    rp_r;                              // Read pointer
    logic [AW:0]      cnt_r;                             // Fill level
    logic             push;                              // Accepted push
    logic             pop;                               // Accepted pop

    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];
    assign count     = cnt_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= push ? wp_r + 1'b1 : wp_r;
            rp_r  <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // fvr_fifo

////////////////////////////////////////////////////////////////////////////////
// Accelerator top
module fvr_accel
    import fvr_pkg::*;
#(
    parameter logic [63:0] HEADER_VAL = 64'h0000000000001000, // Arbitrary value
    parameter logic [63:0] UID_LO     = 64'h0123456789ABCDEF, // Arbitrary value
    parameter logic [63:0] UID_HI     = 64'hFEDCBA9876543210  // Arbitrary value
) (
    input  wire logic                clock,              // 25 MHz clock
    input  wire logic                resetn,             // Async reset
    input  wire logic                start,              // Launch pulse
    input  wire logic                stall,              // Pause masters
    input  wire logic [ADDR_W-1:0]   input_buffer_ptr,   // Input vector
    input  wire logic [ADDR_W-1:0]   output_buffer_ptr,  // Output vector
    input  wire logic [63:0]         size,               // Element count
    input  wire logic                irq_enable,         // Interrupt enable
    output logic                     busy,               // Run active
    output logic                     done,               // Run finished
    output logic [31:0]              result,             // Float sum
    output logic                     irq,                // Completion irq
    input  wire logic [6:0]          rd_addr,            // Shared read port
    output logic [63:0]              rd_data,            // Read data
    output mem_cmd_t                 rm_cmd,             // Read command
    output logic                     rm_read,            // Read strobe
    input  wire logic                rm_waitrequest,     // Read stall
    input  wire logic [DATA_W-1:0]   rm_readdata,        // Read data
    input  wire logic                rm_readdatavalid,   // Read data valid
    output mem_cmd_t                 wm_cmd,             // Write command
    output logic                     wm_write,           // Write strobe
    output logic [DATA_W-1:0]        wm_writedata,       // Write data
    output logic [63:0]              wm_byteenable,      // All lanes
    input  wire logic                wm_waitrequest,     // Write stall
    input  wire logic                wm_writeresponsevalid // Burst acked
);
    // Single-precision add, round to nearest even, denormals flushed except a larger denormal operand, which is returned as is
    function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] x, y;
        logic [7:0]  d;
        logic [27:0] mx, my, sh, s;
        logic [8:0]  e;
        logic [24:0] r;
        x = (a[30:0] < b[30:0]) ? b : a;
        y = (a[30:0] < b[30:0]) ? a : b;
        if (y[30:23] == 8'h00 || x[30:23] == 8'hFF) return x;
        d  = x[30:23] - y[30:23];
        mx = {2'b01, x[22:0], 3'b000};
        my = {2'b01, y[22:0], 3'b000};
        sh = (d > 8'd27) ? 28'h0 : my >> d;
        sh[0] = sh[0] | ((sh << d) != my) | (d > 8'd27);
        s = (x[31] == y[31]) ? mx + sh : mx - sh;
        if (s == 28'h0) return 32'h00000000;
        e = {1'b0, x[30:23]};
        if (s[27]) begin
            s = {1'b0, s[27:2], s[1] | s[0]};
            e = e + 9'h001;
        end
        for (int i = 0; i < 26; i++) begin
            if (!s[26] && e > 9'h001) begin
                s = s << 1;
                e = e - 9'h001;
            end
        end
        if (!s[26]) return {x[31], 31'h0};
        r = {1'b0, s[26:3]} + 25'(s[2] && (s[1] || s[0] || s[3]));
        if (r[24]) begin
            r = r >> 1;
            e = e + 9'h001;
        end
        if (e >= 9'h0FF) return {x[31], 8'hFF, 23'h0};
        return {x[31], e[7:0], r[22:0]};
    endfunction

    // Burst length for the words still owed
    function automatic logic [2:0] blen(input logic [59:0] left);
        return (left >= 60'(MAX_BURST)) ? MAX_BURST : left[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Run control state
    logic [ADDR_W-1:0] inptr_r, outptr_r;                // Latched pointers
    logic [63:0]       size_r;                           // Latched size
    logic              irq_en_r;                         // Latched enable
    logic              busy_r, done_r, irq_r;            // Status
    logic [31:0]       sum_r, result_r;                  // Running and final sum
    logic [59:0]       words_r;                          // Words in vector
    logic [59:0]       rd_left_r, wr_left_r;             // Words still owed
    logic [59:0]       cmp_k_r;                          // Compute word index
    logic              finish;                           // Completion this cycle
    logic [5:0]        wr_pend_r;                        // Unacked write bursts
    logic [63:0]       rd_data_r;                        // Read port data

    assign busy   = busy_r;
    assign done   = done_r;
    assign result = result_r;
    assign irq    = irq_r;
    assign rd_data = rd_data_r;

    // Configuration latched at launch; extra starts ignored while busy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            inptr_r  <= '0;
            outptr_r <= '0;
            size_r   <= '0;
            words_r  <= '0;
        end else if (start && !busy_r) begin
            inptr_r  <= input_buffer_ptr;
            outptr_r <= output_buffer_ptr;
            size_r   <= size;
            words_r  <= 60'((size + 64'h000000000000000F) >> 4);
        end
    end

    // Interrupt enable is software state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_en_r <= 1'b0;
        end else begin
            irq_en_r <= irq_enable;
        end
    end

    // Busy and done with completion after all acks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            result_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end else if (finish) begin
                busy_r   <= 1'b0;
                done_r   <= 1'b1;
                result_r <= sum_r;
            end
            irq_r <= done_r && irq_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read master with registered return path
    mem_cmd_t          rm_cmd_r;                         // Read command
    logic              rm_read_r;                        // Read strobe
    logic [5:0]        inflight_r;                       // Words requested
    logic              rp_valid_r;                       // Return stage valid
    logic [DATA_W-1:0] rp_data_r;                        // Return stage data
    logic              f_in_ready, f_out_valid, f_pop;   // Buffer handshakes
    logic [DATA_W-1:0] f_out_data, wdata;                // Buffer words
    logic [5:0]        f_count;                          // Buffer level
    logic              rd_issue, rd_acc;                 // Read events

    assign rm_cmd  = rm_cmd_r;
    assign rm_read = rm_read_r;
    // Issue only with room for a whole burst in the buffer
    assign rd_issue = busy_r && !rm_read_r && !stall && rd_left_r != '0 && f_in_ready
                      && (f_count + inflight_r + 6'(MAX_BURST)) <= 6'(FIFO_DEPTH);
    assign rd_acc   = rm_read_r && !rm_waitrequest;

    // Read command and progress
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rm_cmd_r  <= '0;
            rm_read_r <= 1'b0;
            rd_left_r <= '0;
        end else if (start && !busy_r) begin
            rd_left_r <= 60'((size + 64'h000000000000000F) >> 4);
            rm_cmd_r.addr <= {input_buffer_ptr[ADDR_W-1:ALIGN_BITS], 6'h00};
        end else if (rd_issue) begin
            rm_read_r      <= 1'b1;
            rm_cmd_r.burst <= blen(rd_left_r);
        end else if (rd_acc) begin
            rm_read_r     <= 1'b0;
            rd_left_r     <= rd_left_r - 60'(rm_cmd_r.burst);
            rm_cmd_r.addr <= rm_cmd_r.addr + ADDR_W'({rm_cmd_r.burst, 6'h00});
        end
    end

    // Words in flight toward the buffer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            inflight_r <= '0;
        end else begin
            inflight_r <= inflight_r + (rd_acc ? 6'(rm_cmd_r.burst) : 6'h00) - 6'(rp_valid_r);
        end
    end

    // Return pipeline register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rp_valid_r <= 1'b0;
            rp_data_r  <= '0;
        end else begin
            rp_valid_r <= rm_readdatavalid;
            rp_data_r  <= rm_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sixteen lanes in parallel: word sum and incremented word
    logic [31:0] wsum;                                   // Sum of live lanes
    always_comb begin
        wsum  = 32'h00000000;
        wdata = '0;
        for (int i = 0; i < LANES; i++) begin
            if ({cmp_k_r, 4'(i)} < size_r) begin
                wsum = fadd(wsum, rp_data_r[i*LANE_W +: LANE_W]);
                wdata[i*LANE_W +: LANE_W] = fadd(rp_data_r[i*LANE_W +: LANE_W], ONE_F);
            end
        end
    end

    // Accumulate and count computed words
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sum_r   <= '0;
            cmp_k_r <= '0;
        end else if (start && !busy_r) begin
            sum_r   <= '0;
            cmp_k_r <= '0;
        end else if (rp_valid_r) begin
            sum_r   <= fadd(sum_r, wsum);
            cmp_k_r <= cmp_k_r + 60'h1;
        end
    end

    fvr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) buf_u (
        .clock     (clock),
        .resetn    (resetn),
        .in_valid  (rp_valid_r),
        .in_ready  (f_in_ready),
        .in_data   (wdata),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data),
        .count     (f_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write master drains the buffer in bursts
    mem_cmd_t          wm_cmd_r;                         // Write command
    logic              wm_write_r;                       // Write strobe
    logic [DATA_W-1:0] wm_data_r;                        // Write data
    logic [2:0]        beats_r;                          // Beats left in burst
    logic              wr_start, wr_beat;                // Write events

    assign wm_cmd        = wm_cmd_r;
    assign wm_write      = wm_write_r;
    assign wm_writedata  = wm_data_r;
    assign wm_byteenable = {64{wm_write_r}};
    assign wr_beat  = wm_write_r && !wm_waitrequest;
    assign wr_start = busy_r && !wm_write_r && !stall && wr_left_r != '0
                      && f_count >= 6'(blen(wr_left_r));
    assign f_pop    = wr_start || (wr_beat && beats_r > 3'h1);
    assign finish   = busy_r && !start_pending() && wr_left_r == '0 && !wm_write_r
                      && wr_pend_r == '0 && rd_left_r == '0;

    // Blocks completion while words_r is zero for a nonzero size_r
    function automatic logic start_pending();
        return words_r == '0 && size_r != '0;
    endfunction

    // Write command, data and progress
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wm_cmd_r   <= '0;
            wm_write_r <= 1'b0;
            wm_data_r  <= '0;
            beats_r    <= '0;
            wr_left_r  <= '0;
        end else if (start && !busy_r) begin
            wr_left_r     <= 60'((size + 64'h000000000000000F) >> 4);
            wm_cmd_r.addr <= {output_buffer_ptr[ADDR_W-1:ALIGN_BITS], 6'h00};
        end else if (wr_start) begin
            wm_write_r     <= 1'b1;
            wm_cmd_r.burst <= blen(wr_left_r);
            beats_r        <= blen(wr_left_r);
            wm_data_r      <= f_out_data;
        end else if (wr_beat) begin
            wr_left_r <= wr_left_r - 60'h1;
            beats_r   <= beats_r - 3'h1;
            if (beats_r > 3'h1) begin
                wm_data_r <= f_out_data;
            end else begin
                wm_write_r    <= 1'b0;
                wm_cmd_r.addr <= wm_cmd_r.addr + ADDR_W'({wm_cmd_r.burst, 6'h00});
            end
        end
    end

    // Outstanding write bursts; ack and issue may coincide
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= '0;
        end else begin
            wr_pend_r <= wr_pend_r + 6'(wr_start) - 6'(wm_writeresponsevalid);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared read port: identity words below the component window
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= '0;
        end else if (rd_addr < CSR_BASE) begin
            case (rd_addr[5:3])
                ID_HDR:  rd_data_r <= HEADER_VAL;
                ID_LO:   rd_data_r <= UID_LO;
                ID_HI:   rd_data_r <= UID_HI;
                default: rd_data_r <= '0;
            endcase
        end else begin
            case (rd_addr[5:3])
                C_STATUS: rd_data_r <= {62'h0, done_r, busy_r};
                C_RESULT: rd_data_r <= {32'h0, result_r};
                C_INPTR:  rd_data_r <= 64'(inptr_r);
                C_OUTPTR: rd_data_r <= 64'(outptr_r);
                C_SIZE:   rd_data_r <= size_r;
                C_IRQEN:  rd_data_r <= {63'h0, irq_en_r};
                default:  rd_data_r <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence rd_stalled;
        rm_read_r && rm_waitrequest;
    endsequence

    read_align_a: assert property (rm_read_r |-> rm_cmd_r.addr[5:0] == 6'h00)
        else $error("read address not 64-byte aligned");
    burst_max_a: assert property (wm_write_r |-> wm_cmd_r.burst inside {[1:4]})
        else $error("write burst out of range");
    read_hold_a: assert property (rd_stalled |=> rm_read_r && $stable(rm_cmd_r))
        else $error("read command dropped under wait");
    write_hold_a: assert property (wm_write_r && wm_waitrequest |=> wm_write_r && $stable(wm_data_r))
        else $error("write data changed under wait");
    acks_first_a: assert property ($rose(done_r) |-> $past(wr_pend_r) == 6'h00)
        else $error("done before all writes acked");
    irq_gate_a: assert property (irq_r |-> $past(done_r) && $past(irq_en_r))
        else $error("irq without enabled done");
    start_ignore_a: assert property (busy_r && start && !finish |=> busy_r && $stable(words_r))
        else $error("start accepted during run");
    buf_room_a: assert property (rp_valid_r |-> f_in_ready)
        else $error("return word with full buffer");
endmodule // fvr_accel

// File: inc/fvr_pkg.sv
// Constants and carrier types for the float vector reduce accelerator
package fvr_pkg;
    localparam int          DATA_W     = 512;            // Memory word width
    localparam int          LANES      = 16;             // Floats per word
    localparam int          LANE_W     = 32;             // Float width
    localparam int          ADDR_W     = 48;             // Byte address width
    localparam int          BURST_W    = 3;              // Burst count width
    localparam logic [2:0]  MAX_BURST  = 3'h4;           // Longest burst
    localparam int          FIFO_DEPTH = 32;             // Buffer words
    localparam int          ALIGN_BITS = 6;              // 64-byte alignment
    localparam logic [31:0] ONE_F      = 32'h3F800000;   // 1.0f
    localparam logic [6:0]  CSR_BASE   = 7'h40;          // Component window
    localparam logic [2:0]  ID_HDR     = 3'h0;           // Feature header word
    localparam logic [2:0]  ID_LO      = 3'h1;           // Identifier low word
    localparam logic [2:0]  ID_HI      = 3'h2;           // Identifier high word
    localparam logic [2:0]  C_STATUS   = 3'h0;           // Busy and done
    localparam logic [2:0]  C_RESULT   = 3'h1;           // Float sum
    localparam logic [2:0]  C_INPTR    = 3'h2;           // Input pointer
    localparam logic [2:0]  C_OUTPTR   = 3'h3;           // Output pointer
    localparam logic [2:0]  C_SIZE     = 3'h4;           // Element count
    localparam logic [2:0]  C_IRQEN    = 3'h5;           // Interrupt enable

    // Command half of a memory master
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;                        // Byte address
        logic [BURST_W-1:0] burst;                       // Words in burst
    } mem_cmd_t;
endpackage

// File: verif/fvr_mem_model.sv
// Host memory model answering the read and write masters
`timescale 1ns/1ps
module fvr_mem_model
    import fvr_pkg::*;
(
    input  wire logic              clock,                // Clock
    input  wire logic              resetn,               // Async reset
    input  wire mem_cmd_t          rm_cmd,               // Read command
    input  wire logic              rm_read,              // Read strobe
    output logic                   rm_waitrequest,       // Read stall
    output logic [DATA_W-1:0]      rm_readdata,          // Read data
    output logic                   rm_readdatavalid,     // Read valid
    input  wire mem_cmd_t          wm_cmd,               // Write command
    input  wire logic              wm_write,             // Write strobe
    input  wire logic [DATA_W-1:0] wm_writedata,         // Write data
    output logic                   wm_waitrequest,       // Write stall
    output logic                   wm_writeresponsevalid // Burst ack
);
    logic [DATA_W-1:0] mem [0:255]; // Word store
    logic [7:0]        rq [$];      // Pending read words
    logic [7:0]        wa_r;        // Next write word
    logic [2:0]        wn_r;        // Beats left
    logic [3:0]        tick_r;      // Stall pattern
    assign rm_waitrequest = (tick_r[1:0] == 2'h0);
    assign wm_waitrequest = (tick_r[1:0] == 2'h2);
    // Read side: queue burst words, return them with gaps
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 4'h0;
            rm_readdatavalid <= 1'b0;
            rm_readdata <= '0;
            rq.delete();
        end else begin
            tick_r <= tick_r + 4'h1;
            rm_readdatavalid <= 1'b0;
            rm_readdata <= ~rm_readdata; // No stale data between words
            if (rq.size() != 0 && tick_r[2:0] != 3'h3) begin
                rm_readdatavalid <= 1'b1;
                rm_readdata <= mem[rq.pop_front()];
            end
            if (rm_read && !rm_waitrequest)
                for (int b = 0; b < int'(rm_cmd.burst); b++) rq.push_back(rm_cmd.addr[13:6] + 8'(b));
        end
    end
    // Write side: store beats, acknowledge after the last beat
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wn_r <= 3'h0;
            wm_writeresponsevalid <= 1'b0;
        end else begin
            wm_writeresponsevalid <= 1'b0;
            if (wm_write && !wm_waitrequest) begin
                mem[wn_r == 3'h0 ? wm_cmd.addr[13:6] : wa_r] <= wm_writedata;
                wa_r <= (wn_r == 3'h0 ? wm_cmd.addr[13:6] : wa_r) + 8'h1;
                wn_r <= (wn_r == 3'h0 ? wm_cmd.burst : wn_r) - 3'h1;
                wm_writeresponsevalid <= ((wn_r == 3'h0 ? wm_cmd.burst : wn_r) == 3'h1);
            end
        end
    end
    // Input words alternate 2.0 and 1.0 per lane; output area prefilled
    initial for (int j = 0; j < 256; j++) mem[j] = (j < 128) ? {8{32'h3F800000, 32'h40000000}} : {16{32'hA5A5A5A5}};
endmodule // fvr_mem_model

// File: verif/tb_fvr_accel.sv
// Bench for the float vector reduce accelerator
`timescale 1ns/1ps
module tb_fvr_accel;
    import fvr_pkg::*;
    logic              clock = 1'b0, resetn = 1'b0, start = 1'b0, irq_enable = 1'b0, stall = 1'b0; // Inputs
    logic [63:0]       size = 64'h0;                         // Element count
    logic [6:0]        rd_addr = 7'h00;                      // Read port address
    logic              busy, done, irq, rm_read, wm_write;   // Status and strobes
    logic              rm_waitrequest, rm_readdatavalid, wm_waitrequest, wm_writeresponsevalid;
    logic [31:0]       result;                               // Float sum
    logic [63:0]       rd_data, wm_byteenable;               // Read data, enables
    logic [DATA_W-1:0] rm_readdata, wm_writedata;            // Memory words
    mem_cmd_t          rm_cmd, wm_cmd;                       // Commands
    int                error_cnt = 0, checked = 0;           // Tallies
    always #20 clock = ~clock;
    fvr_accel #(.HEADER_VAL(64'h00000000000000A1), .UID_LO(64'h00000000000000B2),
        .UID_HI(64'h00000000000000C3)) i_fvr_accel (.clock(clock), .resetn(resetn), .start(start),
        .stall(stall), .input_buffer_ptr(48'h1000), .output_buffer_ptr(48'h2000), .size(size),
        .irq_enable(irq_enable), .busy(busy), .done(done), .result(result), .irq(irq), .rd_addr(rd_addr),
        .rd_data(rd_data), .rm_cmd(rm_cmd), .rm_read(rm_read), .rm_waitrequest(rm_waitrequest),
        .rm_readdata(rm_readdata), .rm_readdatavalid(rm_readdatavalid), .wm_cmd(wm_cmd), .wm_write(wm_write),
        .wm_writedata(wm_writedata), .wm_byteenable(wm_byteenable), .wm_waitrequest(wm_waitrequest),
        .wm_writeresponsevalid(wm_writeresponsevalid));
    fvr_mem_model i_fvr_mem_model (.clock(clock), .resetn(resetn), .rm_cmd(rm_cmd), .rm_read(rm_read),
        .rm_waitrequest(rm_waitrequest), .rm_readdata(rm_readdata), .rm_readdatavalid(rm_readdatavalid),
        .wm_cmd(wm_cmd), .wm_write(wm_write), .wm_writedata(wm_writedata), .wm_waitrequest(wm_waitrequest),
        .wm_writeresponsevalid(wm_writeresponsevalid));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read port access, data one cycle after address
    task automatic rd(input logic [6:0] a, input logic [63:0] exp);
        @(posedge clock);
        rd_addr <= a;
        @(posedge clock);
        #1 chk(rd_data, exp);
    endtask
    // Byte enables cover the whole word on every beat
    always @(posedge clock) if (wm_write === 1'b1) chk(wm_byteenable, {64{1'b1}});
    // One run: launch, refused restart for a nonzero size, completion, memory contents
    task automatic run(input logic [63:0] n, input logic en, input logic [31:0] sum);
        int k;
        @(posedge clock);
        size <= n;
        irq_enable <= en;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        if (n != 0) begin
            @(posedge clock);
            size <= 64'h5;
            start <= 1'b1; // Ignored while busy
            stall <= 1'b1;
            @(posedge clock);
            start <= 1'b0;
            repeat (20) @(posedge clock);
            chk(done, 1'b0);
            chk(wm_write, 1'b0);
            stall <= 1'b0;
        end
        @(posedge clock) #1; // Old done from the last run is gone now
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clock) #1;
        if (k == 3000) begin
            chk(64'h0, 64'h1);
            wrap_up();
        end
        chk(result, sum);
        chk(busy, 1'b0);
        @(posedge clock) #1 chk(irq, en);
        for (k = 0; k < (n + 15) / 16 * 16; k++)
            chk(i_fvr_mem_model.mem[128 + k / 16][k % 16 * 32 +: 32],
                k >= n ? 32'h0 : k % 2 ? 32'h40000000 : 32'h40400000);
        if (n != 0) chk(i_fvr_mem_model.mem[128 + k / 16], {16{32'hA5A5A5A5}});
        rd(7'h40, 64'h2);
        rd(7'h48, {32'h0, sum});
        rd(7'h60, n);
        rd(7'h50, 64'h1000);
        rd(7'h58, 64'h2000);
        rd(7'h68, {63'h0, en});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(7'h00, 64'hA1);
        rd(7'h08, 64'hB2);
        rd(7'h10, 64'hC3);
        rd(7'h78, 64'h0);
        run(64'd20, 1'b1, 32'h41F00000);
        run(64'd64, 1'b0, 32'h42C00000);
        run(64'd0, 1'b1, 32'h0);
        wrap_up();
    end
endmodule // tb_fvr_accel
